// ==== design/dcdac_if.sv ====
`timescale 1ns/1ns
interface dcdac_if;
   logic scl_o;
   logic scl_oe;
   logic sda_m_o;
   logic sda_m_oe;
   logic sda_s_o;
   logic sda_s_oe;
   logic scl;
   logic sda;
   // ************************************************
   // open-drain wire: low while any end drives
   // ************************************************
   assign scl = !(scl_oe && !scl_o);
   assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
   modport dev (input scl, input sda, output sda_s_o, output sda_s_oe);
   modport ctl (input scl, input sda, output scl_o, output scl_oe,
                output sda_m_o, output sda_m_oe);
endinterface

// ==== design/dcdac_master.sv ====
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ns
module dcdac_master
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [3:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   dcdac_if.ctl             bus
);
   typedef enum logic [2:0] {DCM_IDLE, DCM_START, DCM_BIT, DCM_STOP1, DCM_STOP2, DCM_FREE}
      dcdac_mst_t;
   dcdac_mst_t  st_q;
   logic [7:0]  loc_q, wdat_q, rdat_q;
   logic [26:0] bytes_q;
   logic [1:0]  nbytes_q, byte_q;
   logic        rd_q, busy_q, nack_q, scl_q, sda_q, ph_q;
   logic [3:0]  bit_q;
   logic [7:0]  div_q;
   logic [7:0]  cur_q;
   logic        tick;
   logic        req;
   logic [2:0]  sda_sync_q;
   logic        sda_s;
   assign tick = (div_q == 8'(dcdac_pkg::DCDAC_HALF_CYC - 1));
   assign req  = cyc_i && stb_i && !ack_o;
   assign bus.scl_o    = scl_q;
   assign bus.scl_oe   = !scl_q;
   assign bus.sda_m_o  = sda_q;
   assign bus.sda_m_oe = !sda_q;
   // ************************************************
   // wishbone slave: command, location, data, status
   // ************************************************
   always_ff @(posedge clk_i)
      if (rst_i)
      begin
         ack_o  <= 1'b0;
         dat_o  <= 32'h0;
         loc_q  <= 8'h00;
         wdat_q <= 8'h00;
      end
      else if (ce_i)
      begin
         ack_o <= req;
         if (req && we_i && sel_i[0] && adr_i == dcdac_pkg::DCDAC_REG_LOC)
            loc_q <= dat_i[7:0];
         if (req && we_i && sel_i[0] && adr_i == dcdac_pkg::DCDAC_REG_DATA)
            wdat_q <= dat_i[7:0];
         unique case (adr_i)
            dcdac_pkg::DCDAC_REG_LOC:  dat_o <= {24'h0, loc_q};
            dcdac_pkg::DCDAC_REG_DATA: dat_o <= {24'h0, rdat_q};
            dcdac_pkg::DCDAC_REG_STAT: dat_o <= {30'h0, nack_q, busy_q};
            default:                   dat_o <= 32'h0;
         endcase
      end
   // three stages; a change counts once the last two agree
   always_ff @(posedge clk_i)
      if (rst_i)
      begin
         sda_sync_q <= 3'b111;
         sda_s      <= 1'b1;
      end
      else if (ce_i)
      begin
         sda_sync_q <= {sda_sync_q[1:0], bus.sda};
         if (sda_sync_q[1] == sda_sync_q[2])
            sda_s <= sda_sync_q[2];
      end
   // ************************************************
   // bit engine; the master makes scl by division
   // ************************************************
   always_ff @(posedge clk_i)
      if (rst_i)
      begin
         st_q <= DCM_IDLE; scl_q <= 1'b1; sda_q <= 1'b1; busy_q <= 1'b0;
         nack_q <= 1'b0; rd_q <= 1'b0; div_q <= 8'h00; bit_q <= 4'h0;
         ph_q <= 1'b0; byte_q <= 2'd0; nbytes_q <= 2'd0; cur_q <= 8'h00;
         bytes_q <= 27'h0; rdat_q <= 8'h00;
      end
      else if (ce_i)
      begin
         div_q <= (st_q == DCM_IDLE || tick) ? 8'h00 : div_q + 8'h01;
         unique case (st_q)
            DCM_IDLE:
               if (req && we_i && sel_i[0] && adr_i == dcdac_pkg::DCDAC_REG_CMD
                   && (dat_i[dcdac_pkg::DCDAC_CMD_WRITE] || dat_i[dcdac_pkg::DCDAC_CMD_READ]))
               begin
                  rd_q     <= dat_i[dcdac_pkg::DCDAC_CMD_READ];
                  busy_q   <= 1'b1;
                  nack_q   <= 1'b0;
                  st_q     <= DCM_START;
                  sda_q    <= 1'b0;
                  nbytes_q <= dat_i[dcdac_pkg::DCDAC_CMD_READ] ? 2'd2 : 2'd3;
                  cur_q    <= dat_i[dcdac_pkg::DCDAC_CMD_READ] ?
                              dcdac_pkg::DCDAC_ADDR_RD : dcdac_pkg::DCDAC_ADDR_WR;
                  // location sits on top, so it is the first byte shifted out
                  bytes_q  <= {loc_q, 1'b0, wdat_q, 1'b0, 9'h0};
               end
            DCM_START:
               if (tick)
               begin
                  scl_q <= 1'b0;
                  st_q  <= DCM_BIT;
                  bit_q <= 4'h0;
                  ph_q  <= 1'b0;
                  byte_q <= 2'd0;
               end
            DCM_BIT:
               if (tick)
               begin
                  ph_q <= !ph_q;
                  if (!ph_q)
                  begin
                     // data was set while scl low, now scl rises
                     scl_q <= 1'b1;
                  end
                  else
                  begin
                     scl_q <= 1'b0;
                     if (bit_q < 4'd8)
                        rdat_q <= {rdat_q[6:0], sda_s};
                     if (bit_q == 4'd8 && !(rd_q && byte_q == 2'd1))
                        nack_q <= nack_q | sda_s;
                     if (bit_q == 4'd8)
                     begin
                        bit_q  <= 4'h0;
                        byte_q <= byte_q + 2'd1;
                        cur_q  <= bytes_q[26:19];
                        bytes_q <= {bytes_q[17:0], 9'h0};
                     end
                     else
                        bit_q <= bit_q + 4'h1;
                  end
               end
               else if (div_q == 8'h01 && !ph_q)
               begin
                  if (byte_q == nbytes_q || (nack_q && byte_q != 2'd0))
                  begin
                     sda_q <= 1'b0;
                     st_q  <= DCM_STOP1;
                  end
                  else if (bit_q < 4'd8)
                     sda_q <= (rd_q && byte_q == 2'd1) ? 1'b1 : cur_q[3'(7 - bit_q)];
                  else
                     sda_q <= 1'b1; // releases for slave ack, nacks a read
               end
            DCM_STOP1:
               if (tick)
               begin
                  scl_q <= 1'b1;
                  st_q  <= DCM_STOP2;
               end
            DCM_STOP2:
               if (tick)
               begin
                  sda_q  <= 1'b1;
                  st_q   <= DCM_FREE;
               end
            DCM_FREE:
               // bus stays idle a half period before the next start
               if (tick)
               begin
                  busy_q <= 1'b0;
                  st_q   <= DCM_IDLE;
               end
            default:
               st_q <= DCM_IDLE;
         endcase
      end
endmodule

// ==== design/dcdac_pkg.sv ====
package dcdac_pkg;
   // ************************************************
   // register map and field layout
   // ************************************************
   localparam logic [7:0] DCDAC_ADDR_WR    = 8'h90;
   localparam logic [7:0] DCDAC_ADDR_RD    = 8'h91;
   localparam logic [7:0] DCDAC_LOC_FIRST  = 8'hF8;
   localparam logic [7:0] DCDAC_LOC_SECOND = 8'hF9;
   localparam int         DCDAC_SIGN_BIT   = 7;
   localparam int         DCDAC_MAG_W      = 7;
   localparam logic [7:0] DCDAC_CTRL_RST   = 8'h00;
   localparam logic [6:0] DCDAC_MAG_STEPS  = 7'h7F;
   // ************************************************
   // master timing and its own register map
   // ************************************************
   localparam int         DCDAC_HALF_NS    = 80;
   localparam int         DCDAC_CLK_NS     = 8;
   localparam int         DCDAC_HALF_CYC   = DCDAC_HALF_NS / DCDAC_CLK_NS;
   localparam logic [3:0] DCDAC_REG_CMD    = 4'h0;
   localparam logic [3:0] DCDAC_REG_LOC    = 4'h4;
   localparam logic [3:0] DCDAC_REG_DATA   = 4'h8;
   localparam logic [3:0] DCDAC_REG_STAT   = 4'hC;
   localparam int         DCDAC_CMD_WRITE  = 0;
   localparam int         DCDAC_CMD_READ   = 1;
endpackage

// ==== design/dcdac_slave.sv ====
`timescale 1ns/1ns
// Overview of operation
// - F8h drives first, F9h second channel
// - eight bits, sign on top, magnitude below
// - sign zero sinks, sign one sources
// - zero magnitude gives zero current
// - both registers reset to zero
// - 127 steps per direction, code over 127
// - answers to address byte 90h
// - master makes every clock and condition
// - start is sda falling while scl high
// - stop is sda rising while scl high
// - repeated start restarts the transfer
// - transmitter changes sda only scl low
// - sda stable through scl high phase
// - idle between stop and start
// - first byte: address then read flag
// - wrong address ignored until next start
// - write: address, location, data, stop
// - msb first, ninth bit acknowledges
module dcdac_slave
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   output logic [7:0]      current_output_first_o,
   output logic [7:0]      current_output_second_o,
   output logic            first_sourcing_o,
   output logic            second_sourcing_o,
   output logic [6:0]      first_magnitude_code_o,
   output logic [6:0]      second_magnitude_code_o,
   output logic            bus_idle_o,
   dcdac_if.dev            bus
);
   typedef enum logic [2:0] {DCS_IGNORE, DCS_ADDR, DCS_LOC, DCS_DATA, DCS_READ}
      dcdac_slv_t;
   dcdac_slv_t st_q;
   logic [2:0] scl_p_q, sda_p_q;
   logic       scl_s_q, sda_s_q;
   logic       scl_rise, scl_fall, start_ev, stop_ev;
   logic [7:0] shift_q, loc_q, rd_q;
   logic [3:0] bit_q;
   logic       ackd_q, sda_oe_q;
   // magnitude path: zero code forces zero current either way
   function automatic logic [6:0] dcdac_mag(input logic [7:0] r);
      return r[dcdac_pkg::DCDAC_MAG_W-1:0];
   endfunction
   assign bus.sda_s_o  = 1'b0;
   assign bus.sda_s_oe = sda_oe_q;
   // ************************************************
   // pin synchronisers: change counts when 2nd and 3rd agree
   // ************************************************
   always_ff @(posedge clk_i)
      if (rst_i)
      begin
         scl_p_q <= 3'b111;
         sda_p_q <= 3'b111;
         scl_s_q <= 1'b1;
         sda_s_q <= 1'b1;
      end
      else if (ce_i)
      begin
         scl_p_q <= {scl_p_q[1:0], bus.scl};
         sda_p_q <= {sda_p_q[1:0], bus.sda};
         if (scl_p_q[1] == scl_p_q[2])
            scl_s_q <= scl_p_q[2];
         if (sda_p_q[1] == sda_p_q[2])
            sda_s_q <= sda_p_q[2];
      end
   assign scl_rise = (scl_p_q[1] == scl_p_q[2]) && scl_p_q[2] && !scl_s_q;
   assign scl_fall = (scl_p_q[1] == scl_p_q[2]) && !scl_p_q[2] && scl_s_q;
   // scl taken as steady high, so data edges are conditions
   assign start_ev = scl_s_q && (sda_p_q[1] == sda_p_q[2]) && !sda_p_q[2] && sda_s_q;
   assign stop_ev  = scl_s_q && (sda_p_q[1] == sda_p_q[2]) && sda_p_q[2] && !sda_s_q;
   // ************************************************
   // protocol engine
   // ************************************************
   always_ff @(posedge clk_i)
      if (rst_i)
      begin
         st_q <= DCS_IGNORE; shift_q <= 8'h00; bit_q <= 4'h0; loc_q <= 8'h00;
         ackd_q <= 1'b0; sda_oe_q <= 1'b0; rd_q <= 8'h00; bus_idle_o <= 1'b1;
         current_output_first_o  <= dcdac_pkg::DCDAC_CTRL_RST;
         current_output_second_o <= dcdac_pkg::DCDAC_CTRL_RST;
      end
      else if (ce_i)
      begin
         if (start_ev)
         begin
            st_q       <= DCS_ADDR;
            bit_q      <= 4'h0;
            sda_oe_q   <= 1'b0;
            bus_idle_o <= 1'b0;
         end
         else if (stop_ev)
         begin
            st_q       <= DCS_IGNORE;
            sda_oe_q   <= 1'b0;
            bus_idle_o <= 1'b1;
         end
         else if (st_q != DCS_IGNORE && scl_rise)
         begin
            if (bit_q < 4'd8)
               shift_q <= {shift_q[6:0], sda_s_q};
            else if (st_q == DCS_READ && sda_s_q)
               st_q <= DCS_IGNORE;
            bit_q <= (bit_q == 4'd8) ? 4'h0 : bit_q + 4'h1;
         end
         else if (st_q != DCS_IGNORE && scl_fall)
         begin
            if (bit_q == 4'd8 && st_q != DCS_READ)
               unique case (st_q)
                  DCS_ADDR:
                     if (shift_q[7:1] == dcdac_pkg::DCDAC_ADDR_WR[7:1])
                     begin
                        sda_oe_q <= 1'b1;
                        st_q     <= shift_q[0] ? DCS_READ : DCS_LOC;
                        rd_q     <= (loc_q == dcdac_pkg::DCDAC_LOC_SECOND) ?
                                    current_output_second_o : current_output_first_o;
                        if (shift_q[0])
                           bit_q <= 4'hF;
                     end
                     else
                        st_q <= DCS_IGNORE;
                  DCS_LOC:
                  begin
                     sda_oe_q <= 1'b1;
                     loc_q    <= shift_q;
                     st_q     <= DCS_DATA;
                  end
                  default:
                     sda_oe_q <= 1'b1;
               endcase
            else if (st_q == DCS_READ && (bit_q == 4'hF || bit_q < 4'd8))
            begin
               // first read bit follows the ack, whose rise wrapped the parked bit_q to zero
               sda_oe_q <= !rd_q[7];
               rd_q     <= {rd_q[6:0], 1'b0};
               if (bit_q == 4'hF)
                  bit_q <= 4'h0;
            end
            else if (bit_q == 4'h0 && st_q != DCS_READ)
            begin
               sda_oe_q <= 1'b0;
               if (st_q == DCS_DATA && ackd_q)
               begin
                  ackd_q <= 1'b0;
                  if (loc_q == dcdac_pkg::DCDAC_LOC_FIRST)
                     current_output_first_o <= shift_q;
                  else if (loc_q == dcdac_pkg::DCDAC_LOC_SECOND)
                     current_output_second_o <= shift_q;
               end
            end
            else
               sda_oe_q <= 1'b0;
            if (st_q == DCS_DATA && bit_q == 4'd8)
               ackd_q <= 1'b1;
            if (st_q == DCS_READ && bit_q == 4'd8)
               sda_oe_q <= 1'b0;
         end
      end
   // ************************************************
   // decoded channel outputs
   // ************************************************
   always_ff @(posedge clk_i)
      if (rst_i)
      begin
         first_sourcing_o        <= 1'b0;
         second_sourcing_o       <= 1'b0;
         first_magnitude_code_o  <= 7'h00;
         second_magnitude_code_o <= 7'h00;
      end
      else if (ce_i)
      begin
         first_sourcing_o        <= current_output_first_o[dcdac_pkg::DCDAC_SIGN_BIT];
         second_sourcing_o       <= current_output_second_o[dcdac_pkg::DCDAC_SIGN_BIT];
         first_magnitude_code_o  <= dcdac_mag(current_output_first_o);
         second_magnitude_code_o <= dcdac_mag(current_output_second_o);
      end
endmodule

// ==== verif/dcdac_chk.sv ====
`timescale 1ns/1ns
module dcdac_chk
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic scl,
   input  wire logic sda,
   input  wire logic sda_s_oe
);
   // ********
   // bit tracking on the wire
   // ********
   logic       scl_q;
   logic       sda_q;
   logic [3:0] cnt_q;
   logic [7:0] sh_q;
   logic       first_q;
   logic       rd_q;
   wire        start_w = scl && scl_q && sda_q && !sda;
   wire        rise_w  = scl && !scl_q;
   always_ff @(posedge clk_i)
   begin
      scl_q <= scl;
      sda_q <= sda;
   end
   // count wraps after the ninth bit, so a restart only lands on count zero
   always_ff @(posedge clk_i)
   begin
      if (rst_i || start_w)
         cnt_q <= 4'h0;
      else if (rise_w)
         cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
   end
   always_ff @(posedge clk_i)
   begin
      if (rise_w && cnt_q != 4'h8)
         sh_q <= {sh_q[6:0], sda};
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i || start_w)
         first_q <= 1'b1;
      else if (rise_w && cnt_q == 4'h8)
         first_q <= 1'b0;
   end
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         rd_q <= 1'b0;
      else if (rise_w && cnt_q == 4'h8 && first_q)
         rd_q <= sh_q[0];
   end
   // ********
   // properties
   // ********
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_start;
      scl && $past(scl) && $fell(sda);
   endsequence
   sequence s_stop;
      scl && $past(scl) && $rose(sda);
   endsequence
   sequence s_ack_slot;
      rise_w && cnt_q == 4'h8;
   endsequence
   property p_scl_high;
      $rose(scl) |-> scl[*8];
   endproperty
   property p_scl_low;
      $fell(scl) |-> (!scl)[*8];
   endproperty
   property p_start;
      s_start |-> scl[*2] ##[1:30] !scl;
   endproperty
   property p_stop;
      s_stop |-> (scl && sda)[*8];
   endproperty
   property p_bit_hold;
      rise_w && cnt_q != 4'h0 |-> $stable(sda)[*8];
   endproperty
   property p_slave_edge;
      $changed(sda_s_oe) |-> !scl;
   endproperty
   property p_addr_ack;
      s_ack_slot ##0 first_q |-> sda == (sh_q[7:1] != dcdac_pkg::DCDAC_ADDR_WR[7:1]);
   endproperty
   property p_data_ack;
      s_ack_slot ##0 !first_q |-> sda == rd_q;
   endproperty
   a_scl_high: assert property (p_scl_high)
      else $error("scl high phase too short");
   a_scl_low: assert property (p_scl_low)
      else $error("scl low phase too short");
   a_start: assert property (p_start)
      else $error("start not followed by clocking");
   a_stop: assert property (p_stop)
      else $error("bus not idle after stop");
   a_bit_hold: assert property (p_bit_hold)
      else $error("sda moved during scl high");
   a_slave_edge: assert property (p_slave_edge)
      else $error("slave drive changed while scl high");
   a_addr_ack: assert property (p_addr_ack)
      else $error("wrong answer to address byte");
   a_data_ack: assert property (p_data_ack)
      else $error("wrong acknowledge after data byte");
endmodule

// ==== verif/tb_dual_current_dac_i2c_slave.sv ====
`timescale 1ns/1ns
module tb_dual_current_dac_i2c_slave;
   typedef struct packed {logic [7:0] loc; logic [7:0] dat; logic [7:0] e1; logic [7:0] e2;} dcdac_row_t;
   logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, idle_a, idle_b, ackb;
   logic        src_a1, src_a2;
   logic [3:0]  adr_i;
   logic [31:0] dat_i, dat_o, rd;
   logic [7:0]  out_a1, out_a2, out_b1, out_b2;
   logic [6:0]  mag_a1, mag_a2;
   int          miscompares;
   int          check_count;
   dcdac_row_t  rows [7] = '{'{8'hF8, 8'hAA, 8'hAA, 8'h00}, '{8'hF9, 8'h2A, 8'hAA, 8'h2A},
      '{8'hF9, 8'h80, 8'hAA, 8'h80}, '{8'hF8, 8'h7F, 8'h7F, 8'h80}, '{8'hFA, 8'h11, 8'h7F, 8'h80},
      '{8'hF7, 8'h33, 8'h7F, 8'h80}, '{8'hF9, 8'h01, 8'h7F, 8'h01}};
   dcdac_if     bus_a ();
   dcdac_if     bus_b ();
   dcdac_master u_dcdac_master (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o),
      .ack_o(ack_o), .bus(bus_a));
   dcdac_slave  u_dcdac_slave (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .current_output_first_o(out_a1), .current_output_second_o(out_a2),
      .first_sourcing_o(src_a1), .second_sourcing_o(src_a2), .first_magnitude_code_o(mag_a1),
      .second_magnitude_code_o(mag_a2), .bus_idle_o(idle_a), .bus(bus_a));
   // second slave faces a bit-banged master that can misbehave
   dcdac_slave  u_dcdac_slave_b (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
      .current_output_first_o(out_b1), .current_output_second_o(out_b2),
      .first_sourcing_o(), .second_sourcing_o(), .first_magnitude_code_o(),
      .second_magnitude_code_o(), .bus_idle_o(idle_b), .bus(bus_b));
   dcdac_chk    u_dcdac_chk (.clk_i(clk_i), .rst_i(rst_i), .scl(bus_a.scl), .sda(bus_a.sda),
      .sda_s_oe(bus_a.sda_s_oe));
   initial
   begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   // ********
   // checking and bus tasks
   // ********
   task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= a;
      dat_i <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack_o !== 1'b1 && n < 20);
      if (ack_o !== 1'b1)
      begin
         miscompares++;
         end_of_test();
      end
      rd = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask
   // polls busy; a stuck master ends the run instead of hanging it
   task automatic run_cmd(input logic [31:0] cmd);
      int n;
      n = 0;
      wb(1'b1, dcdac_pkg::DCDAC_REG_CMD, cmd);
      do
      begin
         wb(1'b0, dcdac_pkg::DCDAC_REG_STAT, 32'h0);
         n++;
      end
      while (rd[0] !== 1'b0 && n < 600);
      if (rd[0] !== 1'b0)
      begin
         miscompares++;
         end_of_test();
      end
   endtask
   task automatic bb(input logic c, input logic d);
      @(posedge clk_i);
      bus_b.scl_oe   <= !c;
      bus_b.sda_m_oe <= !d;
      repeat (9) @(posedge clk_i);
   endtask
   task automatic bb_start();
      bb(1'b1, 1'b1);
      bb(1'b1, 1'b0);
      bb(1'b0, 1'b0);
   endtask
   task automatic bb_stop();
      bb(1'b0, 1'b0);
      bb(1'b1, 1'b0);
      bb(1'b1, 1'b1);
   endtask
   // data is set up in the low phase, never at the falling edge itself
   task automatic bb_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
      begin
         bb(1'b0, b[i]);
         bb(1'b1, b[i]);
         bb(1'b0, b[i]);
      end
      bb(1'b0, 1'b1);
      bb(1'b1, 1'b1);
      ackb = !bus_b.sda;
      bb(1'b0, 1'b1);
   endtask
   // ********
   // main sequence
   // ********
   initial
   begin
      rst_i = 1'b1;
      {cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
      {bus_b.scl_o, bus_b.sda_m_o, bus_b.scl_oe, bus_b.sda_m_oe} = 4'h0;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (rows[i])
      begin
         wb(1'b1, dcdac_pkg::DCDAC_REG_LOC, {24'h0, rows[i].loc});
         wb(1'b1, dcdac_pkg::DCDAC_REG_DATA, {24'h0, rows[i].dat});
         run_cmd(32'h1);
         check_val("nack flag", 32'h0, {31'h0, rd[1]});
         check_val("first", {24'h0, rows[i].e1}, {24'h0, out_a1});
         check_val("second", {24'h0, rows[i].e2}, {24'h0, out_a2});
         check_val("signs", {30'h0, rows[i].e1[7], rows[i].e2[7]}, {30'h0, src_a1, src_a2});
         check_val("codes", {18'h0, rows[i].e1[6:0], rows[i].e2[6:0]}, {18'h0, mag_a1, mag_a2});
         if (rows[i].loc[7:1] == 7'h7C)
         begin
            run_cmd(32'h2);
            wb(1'b0, dcdac_pkg::DCDAC_REG_DATA, 32'h0);
            check_val("read back", {24'h0, rows[i].loc[0] ? rows[i].e2 : rows[i].e1}, {24'h0, rd[7:0]});
         end
      end
      rst_i <= 1'b1;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      check_val("reset outputs", 32'h0, {out_a1, out_a2, mag_a1, mag_a2, src_a1, src_a2});
      check_val("reset b", 32'h0, {16'h0, out_b1, out_b2});
      check_val("idle", 32'h3, {30'h0, idle_a, idle_b});
      wb(1'b0, 4'h2, 32'h0);
      check_val("unmapped", 32'h0, rd);
      bb_start();
      check_val("busy after start", 32'h0, {31'h0, idle_b});
      bb_byte(8'hA0);
      check_val("foreign address", 32'h0, {31'h0, ackb});
      bb_byte(dcdac_pkg::DCDAC_LOC_FIRST);
      check_val("ignored byte", 32'h0, {31'h0, ackb});
      bb_byte(8'h55);
      bb_stop();
      check_val("ignored write", 32'h0, {24'h0, out_b1});
      check_val("idle after stop", 32'h1, {31'h0, idle_b});
      bb_start();
      bb_byte(dcdac_pkg::DCDAC_ADDR_WR);
      check_val("own address", 32'h1, {31'h0, ackb});
      bb_byte(dcdac_pkg::DCDAC_LOC_FIRST);
      bb_start();
      check_val("restart busy", 32'h0, {31'h0, idle_b});
      bb_byte(dcdac_pkg::DCDAC_ADDR_WR);
      bb_byte(dcdac_pkg::DCDAC_LOC_SECOND);
      bb_byte(8'h83);
      check_val("data ack", 32'h1, {31'h0, ackb});
      bb_stop();
      check_val("after restart", 32'h0083, {16'h0, out_b1, out_b2});
      end_of_test();
   end
endmodule
